// File: rtl/ttwb_pkg.sv
package ttwb_pkg;

   // bus timing for the link-side engine (one quarter of a bus bit)
   localparam int QTR_NS         = 2500;
   localparam int LINK_PERIOD_PS = 6000;
   localparam int QTR_CYC        = (QTR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int TMR_W          = 10;
   localparam logic [TMR_W-1:0] QTR_LOAD = TMR_W'(QTR_CYC);

   // positions within a nine-clock unit
   localparam logic [3:0] CNT_ACK = 4'h8;
   localparam logic [3:0] CNT_END = 4'h9;

   // commands from the user side of the master
   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ  = 2'h2,
      OP_STOP  = 2'h3
   } ttwb_op_t;

   typedef enum logic [1:0] {
      L_IDLE  = 2'h0,
      L_START = 2'h1,
      L_BITS  = 2'h2,
      L_STOP  = 2'h3
   } ttwb_lst_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_ADDR = 3'h1,
      S_WR   = 3'h2,
      S_RD   = 3'h3,
      S_SKIP = 3'h4
   } ttwb_sst_t;

   // master, system-clock side
   typedef struct packed {
      logic       req_t;
      ttwb_op_t   op;
      logic [7:0] data;
      logic       last;
      logic       ack_p;
      logic       rsp_valid;
      logic [7:0] rsp_data;
      logic       rsp_nack;
      logic       rsp_lost;
   } ttwb_msys_t;

   // master, link-clock side
   typedef struct packed {
      ttwb_lst_t        st;
      logic [1:0]       ph;
      logic [TMR_W-1:0] tmr;
      logic [3:0]       bitn;
      logic [7:0]       sh;
      ttwb_op_t         op;
      logic             last;
      logic             scl_oe;
      logic             sda_oe;
      logic             own;
      logic             busy;
      logic             p_scl;
      logic             p_sda;
      logic             ack_t;
      logic             res_nack;
      logic             res_lost;
   } ttwb_mlnk_t;

   // slave state
   typedef struct packed {
      ttwb_sst_t  st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic       rw;
      logic       scl_oe;
      logic       sda_oe;
      logic       p_scl;
      logic       p_sda;
      logic       rx_valid;
      logic [7:0] rx_data;
      logic       tx_take;
   } ttwb_slv_t;

   // values after reset; idle lines read high
   localparam ttwb_msys_t MSYS_RESET = '0;
   localparam ttwb_mlnk_t MLNK_RESET = '{st: L_IDLE, op: OP_START, p_scl: 1'b1,
                                         p_sda: 1'b1, default: '0};
   localparam ttwb_slv_t  SLV_RESET  = '{st: S_IDLE, p_scl: 1'b1, p_sda: 1'b1,
                                         default: '0};

endpackage

// File: rtl/ttwb_if.sv
`timescale 1ns/1ps
interface ttwb_if;
   logic m_scl_oe;
   logic m_scl_o;
   logic m_sda_oe;
   logic m_sda_o;
   logic s_scl_oe;
   logic s_scl_o;
   logic s_sda_oe;
   logic s_sda_o;
   logic scl;
   logic sda;

   // wired-and with pull-up: any enabled low driver wins, otherwise the line floats high
   assign scl = ~((m_scl_oe & ~m_scl_o) | (s_scl_oe & ~s_scl_o));
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

   modport master (
      output m_scl_oe, m_scl_o, m_sda_oe, m_sda_o,
      input  scl, sda
   );
   modport slave (
      output s_scl_oe, s_scl_o, s_sda_oe, s_sda_o,
      input  scl, sda
   );
endinterface

// File: rtl/ttwb_sync.sv
`timescale 1ns/1ps
module ttwb_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         clk,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // two flops; the first is read by the second only
   always_ff @(posedge clk) begin
      meta_q <= d;
      q      <= meta_q;
   end
endmodule

// File: rtl/ttwb_slave.sv
`timescale 1ns/1ps
module ttwb_slave import ttwb_pkg::*; (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // configuration
   input  wire logic [6:0] own_addr,
   // receive side
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   // transmit side
   input  wire logic [7:0] tx_data,
   output logic            tx_take,
   input  wire logic       hold_scl,
   // bus
   ttwb_if.slave           bus
);
   ttwb_slv_t q_q;
   ttwb_slv_t q_d;
   logic      scl_s;
   logic      sda_s;
   logic      rise;
   logic      fall;
   logic      start_c;
   logic      stop_c;

   // pins are asynchronous to clk_sys
   ttwb_sync #(.W(2)) u_sync (
      .clk (clk_sys),
      .d   ({bus.scl, bus.sda}),
      .q   ({scl_s, sda_s})
   );

   // sda moving while scl is high is a frame marker, never data
   assign rise    = scl_s & ~q_q.p_scl;
   assign fall    = ~scl_s & q_q.p_scl;
   assign start_c = scl_s & q_q.p_scl & q_q.p_sda & ~sda_s;
   assign stop_c  = scl_s & q_q.p_scl & ~q_q.p_sda & sda_s;

   always_comb begin
      q_d          = q_q;
      q_d.p_scl    = scl_s;
      q_d.p_sda    = sda_s;
      q_d.rx_valid = 1'b0;
      q_d.tx_take  = 1'b0;
      // stretch ends as soon as the user lets go
      if (q_q.scl_oe && !hold_scl) begin
         q_d.scl_oe = 1'b0;
      end
      if (start_c) begin
         // a repeated start restarts address reception just like a start
         q_d.st     = S_ADDR;
         q_d.cnt    = 4'h0;
         q_d.sda_oe = 1'b0;
         q_d.scl_oe = 1'b0;
      end else if (stop_c) begin
         q_d.st     = S_IDLE;
         q_d.sda_oe = 1'b0;
         q_d.scl_oe = 1'b0;
      end else if (q_q.st != S_IDLE && q_q.st != S_SKIP) begin
         if (rise) begin
            if (q_q.cnt < CNT_ACK) begin
               q_d.sh = {q_q.sh[6:0], sda_s};
            end else if (q_q.st == S_RD && sda_s) begin
               q_d.st = S_SKIP;
            end
            q_d.cnt = q_q.cnt + 4'h1;
         end
         if (fall) begin
            if (q_q.cnt == CNT_ACK) begin
               unique case (q_q.st)
                  S_ADDR: begin
                     if (q_q.sh[7:1] == own_addr) begin
                        q_d.sda_oe = 1'b1;
                        q_d.rw     = q_q.sh[0];
                     end else begin
                        q_d.st = S_SKIP;
                     end
                  end
                  S_WR: begin
                     q_d.sda_oe   = 1'b1;
                     q_d.rx_valid = 1'b1;
                     q_d.rx_data  = q_q.sh;
                  end
                  S_RD: q_d.sda_oe = 1'b0;
                  default: q_d.sda_oe = 1'b0;
               endcase
            end else if (q_q.cnt == CNT_END) begin
               // end of the nine-clock unit; take up the role set by the direction bit
               q_d.cnt    = 4'h0;
               q_d.sda_oe = 1'b0;
               q_d.scl_oe = hold_scl;
               if ((q_q.st == S_ADDR && q_q.rw) || q_q.st == S_RD) begin
                  q_d.st      = S_RD;
                  q_d.tx      = tx_data;
                  q_d.tx_take = 1'b1;
                  q_d.sda_oe  = ~tx_data[7];
               end else if (q_q.st == S_ADDR) begin
                  q_d.st = S_WR;
               end
            end else if (q_q.st == S_RD) begin
               q_d.sda_oe = ~q_q.tx[3'(4'h7 - q_q.cnt)];
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q_q <= SLV_RESET;
      end else begin
         q_q <= q_d;
      end
   end

   // pins only ever pull low
   assign bus.s_scl_o  = 1'b0;
   assign bus.s_sda_o  = 1'b0;
   assign bus.s_scl_oe = q_q.scl_oe;
   assign bus.s_sda_oe = q_q.sda_oe;
   assign rx_valid     = q_q.rx_valid;
   assign rx_data      = q_q.rx_data;
   assign tx_take      = q_q.tx_take;
endmodule

// File: rtl/ttwb_master.sv
`timescale 1ns/1ps
// Function
// - start: sda falls while scl high
// - bytes shift out most significant first
// - direction bit one reads, zero writes
// - acknowledge is sda pulled low
// - sda changes only while scl low
// - stop: sda rises while scl high
// - master receiver ends last byte without acknowledge
// - repeated start may replace stop
// - unit is eight data plus one acknowledge
// - transmitter releases sda for acknowledge slot
// - master clocks; sample high, change low
// - slave may hold scl low to stall
// - master waits until scl seen high
// - no new start while bus busy
// - sda mismatch loses arbitration, release sda
// - loser also releases scl, reports lost, needs a new start
// - both lines open drain with pull-up
// - enable forces pins open drain
// - pin output data fixed at zero
// - after address ack roles follow direction
// - slave receiver acknowledges every byte
// - lower address wins arbitration naturally
module ttwb_master import ttwb_pkg::*; (
   // system side
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // link side
   input  wire logic       clk_link,
   // configuration
   input  wire logic       port_enable_bit,
   // command
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire ttwb_op_t   cmd_op,
   input  wire logic [7:0] cmd_data,
   input  wire logic       cmd_last,
   // response
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   output logic            rsp_nack,
   output logic            rsp_lost,
   // bus
   ttwb_if.master          bus
);
   ttwb_msys_t s_q;
   ttwb_msys_t s_d;
   ttwb_mlnk_t l_q;
   ttwb_mlnk_t l_d;
   logic       ack_s;
   logic       rst_l;
   logic       req_s;
   logic       en_s;
   logic       scl_s;
   logic       sda_s;
   logic       drv_next;

   // level crossings into the link domain, pins included
   ttwb_sync #(.W(5)) u_lsync (
      .clk (clk_link),
      .d   ({reset, s_q.req_t, port_enable_bit, bus.scl, bus.sda}),
      .q   ({rst_l, req_s, en_s, scl_s, sda_s})
   );

   // the answer toggle back into the system domain
   ttwb_sync #(.W(1)) u_ssync (
      .clk (clk_sys),
      .d   (l_q.ack_t),
      .q   (ack_s)
   );

   // one command in flight; the held command words are the handshake payload
   assign cmd_ready = (s_q.req_t == s_q.ack_p);

   always_comb begin
      s_d           = s_q;
      s_d.rsp_valid = 1'b0;
      if (cmd_valid && cmd_ready) begin
         s_d.req_t = ~s_q.req_t;
         s_d.op    = cmd_op;
         s_d.data  = cmd_data;
         s_d.last  = cmd_last;
      end
      // link results are stable once the toggle has come back
      if (ack_s != s_q.ack_p) begin
         s_d.ack_p     = ack_s;
         s_d.rsp_valid = 1'b1;
         s_d.rsp_data  = l_q.sh;
         s_d.rsp_nack  = l_q.res_nack;
         s_d.rsp_lost  = l_q.res_lost;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_q <= MSYS_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // sda drive for the bit after the current one, taken from the shifted register
   always_comb begin
      if (l_q.bitn + 4'h1 < CNT_ACK) begin
         // the sample phase has already shifted, so the next bit sits at the top
         drv_next = (l_q.op == OP_WRITE) && !l_q.sh[7];
      end else begin
         drv_next = (l_q.op == OP_READ) && !l_q.last;
      end
   end

   // link engine: four quarter-bit phases per bus clock
   always_comb begin
      l_d       = l_q;
      l_d.p_scl = scl_s;
      l_d.p_sda = sda_s;
      // bus busy from start to stop, whoever drives it
      if (scl_s && l_q.p_scl && l_q.p_sda && !sda_s) begin
         l_d.busy = 1'b1;
      end
      if (scl_s && l_q.p_scl && !l_q.p_sda && sda_s) begin
         l_d.busy = 1'b0;
      end
      // phase timer; a stretched clock keeps the high phase from starting
      if (l_q.st != L_IDLE) begin
         if (l_q.ph == 2'h1 && !scl_s) begin
            l_d.tmr = QTR_LOAD;
         end else if (l_q.tmr != '0) begin
            l_d.tmr = l_q.tmr - 1'b1;
         end else begin
            l_d.tmr = QTR_LOAD;
            l_d.ph  = l_q.ph + 2'h1;
         end
      end
      unique case (l_q.st)
         L_IDLE: begin
            if (req_s != l_q.ack_t) begin
               l_d.op       = s_q.op;
               l_d.last     = s_q.last;
               l_d.ph       = 2'h0;
               l_d.tmr      = QTR_LOAD;
               l_d.bitn     = 4'h0;
               l_d.res_nack = 1'b0;
               l_d.res_lost = 1'b0;
               if (!en_s) begin
                  l_d.ack_t    = req_s;
                  l_d.res_lost = 1'b1;
               end else if (s_q.op == OP_START) begin
                  // a start waits for an idle bus unless it is our own restart
                  if (!l_q.busy || l_q.own) begin
                     l_d.st     = L_START;
                     l_d.sda_oe = 1'b0;
                  end
               end else if (!l_q.own) begin
                  l_d.ack_t    = req_s;
                  l_d.res_lost = 1'b1;
               end else if (s_q.op == OP_STOP) begin
                  l_d.st     = L_STOP;
                  l_d.sda_oe = 1'b1;
               end else begin
                  l_d.st     = L_BITS;
                  l_d.sh     = (s_q.op == OP_WRITE) ? s_q.data : 8'hff;
                  l_d.sda_oe = (s_q.op == OP_WRITE) && !s_q.data[7];
               end
            end
         end
         L_START: begin
            if (l_d.ph != l_q.ph) begin
               unique case (l_q.ph)
                  2'h0: l_d.scl_oe = 1'b0;
                  2'h1: l_d.sda_oe = 1'b1;
                  2'h2: l_d.scl_oe = 1'b1;
                  2'h3: begin
                     l_d.own   = 1'b1;
                     l_d.st    = L_IDLE;
                     l_d.ack_t = req_s;
                  end
               endcase
            end
         end
         L_BITS: begin
            if (l_d.ph != l_q.ph) begin
               unique case (l_q.ph)
                  2'h0: l_d.scl_oe = 1'b0;
                  2'h1: begin
                     // sample in the high phase; a low line where we let go means another
                     // master is sending a lower value, so we drop off the bus
                     if (l_q.op == OP_WRITE && l_q.bitn < CNT_ACK && !l_q.sda_oe && !sda_s) begin
                        l_d.scl_oe   = 1'b0;
                        l_d.sda_oe   = 1'b0;
                        l_d.own      = 1'b0;
                        l_d.res_lost = 1'b1;
                        l_d.st       = L_IDLE;
                        l_d.ack_t    = req_s;
                     end else if (l_q.bitn < CNT_ACK) begin
                        l_d.sh = {l_q.sh[6:0], sda_s};
                     end else begin
                        l_d.res_nack = sda_s;
                     end
                  end
                  2'h2: l_d.scl_oe = 1'b1;
                  2'h3: begin
                     if (l_q.bitn == CNT_ACK) begin
                        l_d.sda_oe = 1'b0;
                        l_d.st     = L_IDLE;
                        l_d.ack_t  = req_s;
                     end else begin
                        l_d.bitn   = l_q.bitn + 4'h1;
                        l_d.sda_oe = drv_next;
                     end
                  end
               endcase
            end
         end
         L_STOP: begin
            if (l_d.ph != l_q.ph) begin
               unique case (l_q.ph)
                  2'h0: l_d.scl_oe = 1'b0;
                  2'h1: l_d.sda_oe = 1'b0;
                  2'h2: l_d.own    = 1'b0;
                  2'h3: begin
                     l_d.st    = L_IDLE;
                     l_d.ack_t = req_s;
                  end
               endcase
            end
         end
      endcase
      // disabling drops the bus at once; a pending command is then refused
      if (!en_s) begin
         l_d.scl_oe = 1'b0;
         l_d.sda_oe = 1'b0;
         l_d.own    = 1'b0;
         if (l_q.st != L_IDLE) begin
            l_d.st = L_IDLE;
         end
      end
   end

   always_ff @(posedge clk_link) begin
      if (rst_l) begin
         l_q <= MLNK_RESET;
      end else begin
         l_q <= l_d;
      end
   end

   // open drain only: output data held at zero, enables taken straight from the link registers, which the port enable clears
   assign bus.m_scl_o  = 1'b0;
   assign bus.m_sda_o  = 1'b0;
   assign bus.m_scl_oe = l_q.scl_oe;
   assign bus.m_sda_oe = l_q.sda_oe;
   assign rsp_valid    = s_q.rsp_valid;
   assign rsp_data     = s_q.rsp_data;
   assign rsp_nack     = s_q.rsp_nack;
   assign rsp_lost     = s_q.rsp_lost;
endmodule

// File: verif/ttwb_props.sv
`timescale 1ns/1ps
module ttwb_props (
   // clock and reset
   input logic clk_sys,
   input logic reset,
   // master and slave pins
   input logic m_scl_oe,
   input logic m_scl_o,
   input logic m_sda_oe,
   input logic m_sda_o,
   input logic s_scl_oe,
   input logic s_scl_o,
   input logic s_sda_oe,
   input logic s_sda_o,
   // resolved lines
   input logic scl,
   input logic sda
);
   logic       scl_p_q;
   logic       sda_p_q;
   logic       addr_q;
   logic       rw_q;
   logic [3:0] cnt_q;
   wire        start_w = scl && scl_p_q && sda_p_q && !sda;
   wire        stop_w  = scl && scl_p_q && !sda_p_q && sda;
   wire        mtx_w   = addr_q || !rw_q;

   // bit position within a unit; raw lines sampled, so a glitch shows up here too
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         cnt_q   <= 4'h0;
         addr_q  <= 1'b0;
         rw_q    <= 1'b0;
      end else begin
         scl_p_q <= scl;
         sda_p_q <= sda;
         if (start_w || stop_w) begin
            cnt_q  <= 4'h0;
            addr_q <= start_w;
         end else if (scl && !scl_p_q) begin
            cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
            if (cnt_q == 4'h9) addr_q <= 1'b0;
            if (addr_q && cnt_q == 4'h7) rw_q <= sda;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // a settled high phase: two samples in a row
   sequence s_hi;
      scl && scl_p_q;
   endsequence
   sequence s_held;
      !m_scl_oe && s_scl_oe;
   endsequence

   AST_M_PIN_ZERO: assert property (!m_scl_o && !m_sda_o)
      else $error("master pin data not zero");
   AST_S_PIN_ZERO: assert property (!s_scl_o && !s_sda_o)
      else $error("slave pin data not zero");
   AST_STRETCH_LOW: assert property ($rose(s_scl_oe) |-> !$past(scl))
      else $error("slave grabbed scl while high");
   AST_MASTER_WAITS: assert property (s_held |=> !m_scl_oe)
      else $error("master pulled scl during stretch");
   AST_SLAVE_SDA_LOW: assert property ($changed(s_sda_oe) |-> !scl)
      else $error("slave moved sda while scl high");
   AST_SDA_STEADY: assert property (s_hi ##0 (cnt_q inside {[4'h2:4'h9]}) |-> $stable(sda))
      else $error("sda moved inside a bit");
   AST_ACK_RELEASE: assert property (s_hi ##0 (cnt_q == 4'h9 && mtx_w) |-> !m_sda_oe)
      else $error("transmitter held sda in ack slot");
   AST_SLAVE_ACK: assert property (s_hi ##0 (cnt_q == 4'h9 && mtx_w) |-> !sda && s_sda_oe)
      else $error("no slave ack");
   AST_QUIET_READ: assert property (s_hi ##0 (!mtx_w && cnt_q inside {[4'h2:4'h8]}) |-> !m_sda_oe)
      else $error("master drove sda in read byte");
   AST_QUIET_WRITE: assert property (s_hi ##0 (mtx_w && cnt_q inside {[4'h2:4'h8]}) |-> !s_sda_oe)
      else $error("slave drove sda in written byte");
endmodule

// File: verif/two_wire_bus_protocol_core_bench.sv
`timescale 1ns/1ps
module two_wire_bus_protocol_core_bench import ttwb_pkg::*;;
   logic       clk_sys, clk_link, reset;
   logic       en[2], cv[2], cl[2], cr[2], rv[2], rn[2], rl[2];
   ttwb_op_t   co[2];
   logic [7:0] cd[2], rd[2];
   logic       rx_valid, tx_take, hold_scl;
   logic [7:0] rx_data, tx_data, rx_last;
   int         miscompares, compares, takes;
   ttwb_if     bus [2] ();

   // bus 0 joins master and slave, bus 1 joins a master to a rival driven here
   for (genvar g = 0; g < 2; g++) begin : g_m
      ttwb_master i_ttwb_master (.clk_sys(clk_sys), .reset(reset), .clk_link(clk_link),
         .port_enable_bit(en[g]), .cmd_valid(cv[g]), .cmd_ready(cr[g]), .cmd_op(co[g]),
         .cmd_data(cd[g]), .cmd_last(cl[g]), .rsp_valid(rv[g]), .rsp_data(rd[g]),
         .rsp_nack(rn[g]), .rsp_lost(rl[g]), .bus(bus[g].master));
   end
   ttwb_slave i_ttwb_slave (.clk_sys(clk_sys), .reset(reset), .own_addr(7'h2d),
      .rx_valid(rx_valid), .rx_data(rx_data), .tx_data(tx_data), .tx_take(tx_take),
      .hold_scl(hold_scl), .bus(bus[0].slave));
   ttwb_props i_ttwb_props (.clk_sys(clk_sys), .reset(reset),
      .m_scl_oe(bus[0].m_scl_oe), .m_scl_o(bus[0].m_scl_o), .m_sda_oe(bus[0].m_sda_oe),
      .m_sda_o(bus[0].m_sda_o), .s_scl_oe(bus[0].s_scl_oe), .s_scl_o(bus[0].s_scl_o),
      .s_sda_oe(bus[0].s_sda_oe), .s_sda_o(bus[0].s_sda_o), .scl(bus[0].scl),
      .sda(bus[0].sda));

   // clocks with unrelated phase
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      clk_link = 1'b0;
      #1.3;
      forever #3 clk_link = ~clk_link;
   end

   // keep the last received byte and count transmit loads; one process owns both
   always @(posedge clk_sys) begin
      if (rx_valid === 1'b1) rx_last <= rx_data;
      if (reset === 1'b1) begin
         takes <= 0;
      end else if (tx_take === 1'b1) begin
         takes <= takes + 1;
      end
   end

   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic fail(input string msg);
      miscompares++;
      $display("MISMATCH %0t %s", $time, msg);
   endtask
   task automatic chk1(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) fail(msg);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp) fail(msg);
   endtask

   // hold a command from ready until taken; ready drops on the taking edge
   task automatic send(input int m, input ttwb_op_t op, input logic [7:0] d, input logic l);
      int n;
      @(negedge clk_sys);
      for (n = 0; n < 100 && cr[m] !== 1'b1; n++) @(negedge clk_sys);
      if (n >= 100) begin
         fail("not ready");
         close_out();
      end
      cv[m] = 1'b1;
      co[m] = op;
      cd[m] = d;
      cl[m] = l;
      for (n = 0; n < 100 && cr[m] === 1'b1; n++) @(negedge clk_sys);
      cv[m] = 1'b0;
      if (n >= 100) begin
         fail("not taken");
         close_out();
      end
   endtask
   // a byte needs 36 quarters of 418 link cycles, so the bound is generous
   task automatic rwait(input int m, input int bound);
      int n;
      for (n = 0; n < bound && rv[m] !== 1'b1; n++) @(negedge clk_sys);
      if (n >= bound) begin
         fail("no response");
         close_out();
      end
   endtask
   task automatic cmd(input int m, input ttwb_op_t op, input logic [7:0] d, input logic l);
      send(m, op, d, l);
      rwait(m, 30000);
   endtask

   // address and data byte, slave stretching after the address
   task automatic t_write();
      cmd(0, OP_START, 8'h00, 1'b0);
      chk1(rl[0], 1'b0, "start lost");
      hold_scl = 1'b1;
      cmd(0, OP_WRITE, {7'h2d, 1'b0}, 1'b0);
      chk1(rn[0], 1'b0, "addr nack");
      chk8(rd[0], 8'h5a, "addr readback");
      send(0, OP_WRITE, 8'h96, 1'b0);
      repeat (3000) @(negedge clk_sys);
      chk1(bus[0].scl, 1'b0, "scl not held");
      chk1(rv[0], 1'b0, "ran through stretch");
      hold_scl = 1'b0;
      rwait(0, 30000);
      chk1(rn[0], 1'b0, "data nack");
      chk8(rx_last, 8'h96, "slave byte");
      $display("test write done");
   endtask

   // repeated start, read of a last byte, stop
   task automatic t_read();
      int takes0;
      tx_data = 8'hc3;
      takes0 = takes;
      cmd(0, OP_START, 8'h00, 1'b0);
      chk1(rl[0], 1'b0, "restart lost");
      cmd(0, OP_WRITE, {7'h2d, 1'b1}, 1'b0);
      chk1(rn[0], 1'b0, "read addr nack");
      cmd(0, OP_READ, 8'h00, 1'b1);
      chk8(rd[0], 8'hc3, "read byte");
      chk1(rn[0], 1'b1, "last byte acked");
      chk8(8'(takes - takes0), 8'h01, "slave load count");
      cmd(0, OP_STOP, 8'h00, 1'b0);
      chk1(rl[0], 1'b0, "stop lost");
      chk1(bus[0].scl & bus[0].sda, 1'b1, "lines not idle");
      $display("test read done");
   endtask

   // busy bus, lost arbitration, refusals; the rival is this task
   task automatic t_arb();
      en[1] = 1'b1;
      bus[1].s_sda_oe = 1'b1;
      send(1, OP_START, 8'h00, 1'b0);
      repeat (400) @(negedge clk_sys);
      chk1(rv[1] | bus[1].m_sda_oe | bus[1].m_scl_oe, 1'b0, "start on busy bus");
      bus[1].s_sda_oe = 1'b0;
      rwait(1, 4000);
      chk1(rl[1], 1'b0, "start after stop");
      // rival puts a zero while scl is low; ours sends a one first
      bus[1].s_sda_oe = 1'b1;
      cmd(1, OP_WRITE, 8'ha0, 1'b0);
      chk1(rl[1], 1'b1, "not lost");
      chk1(bus[1].m_sda_oe | bus[1].m_scl_oe, 1'b0, "loser drives");
      chk1(bus[1].m_sda_o | bus[1].m_scl_o, 1'b0, "pin data");
      bus[1].s_sda_oe = 1'b0;
      cmd(1, OP_WRITE, 8'h11, 1'b0);
      chk1(rl[1], 1'b1, "write kept bus");
      en[1] = 1'b0;
      cmd(1, OP_START, 8'h00, 1'b0);
      chk1(rl[1], 1'b1, "disabled start");
      $display("test arbitration done");
   endtask

   initial begin
      miscompares = 0;
      compares = 0;
      reset = 1'b1;
      hold_scl = 1'b0;
      tx_data = 8'h00;
      en = '{1'b1, 1'b0};
      cv = '{1'b0, 1'b0};
      cl = '{1'b0, 1'b0};
      co = '{OP_START, OP_START};
      cd = '{8'h00, 8'h00};
      bus[1].s_scl_oe = 1'b0;
      bus[1].s_scl_o = 1'b0;
      bus[1].s_sda_oe = 1'b0;
      bus[1].s_sda_o = 1'b0;
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      repeat (10) @(negedge clk_sys);
      t_write();
      t_read();
      t_arb();
      close_out();
   end
endmodule
